//--- shared/state_readback_regs.svh
`ifndef STATE_READBACK_REGS_SVH
`define STATE_READBACK_REGS_SVH

// byte addresses of the register map
`define CUR_STATE_OFFSET 8'h20
`define COUNTER_SNAP_OFFSET 8'h24
`define ACTION_SNAP_OFFSET 8'h28
`define ID_LOW_OFFSET 8'h2c
`define ID_HIGH_OFFSET 8'h30
`define COUNTER_SELECT_OFFSET 8'h34
`define IRQ_STATUS_OFFSET 8'h38
`define IRQ_MASK_OFFSET 8'h3c

// build configuration
`define TRIGGER_STATE_COUNT 8
`define CAPTURE_GROUP_WIDTH 128
`define ID_CAPTURE_OPTION 1
`define ID_CAPTURE_WIDTH 64

// field positions
`define FINAL_FLAG_BIT 31
`define POS1_LSB 0
`define POS2_LSB 3
`define POS3_LSB 6
`define POS4_LSB 9
`define SELECT_FIELD_W 3
`define IRQ_FINAL_BIT 0
`define IRQ_ID_BIT 1

// reset values
`define STATE_RESET 8'h01
`define COUNTER_SELECT_RESET 12'h000
`define IRQ_MASK_RESET 2'h0

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- shared/state_readback_pkg.sv
package state_readback_pkg;

    typedef enum {RD_IDLE, RD_RESP} rd_state_t;
    typedef enum {WR_COLLECT, WR_RESP} wr_state_t;
    typedef enum {
        SEL_CUR_STATE, SEL_COUNTER_SNAP, SEL_ACTION_SNAP, SEL_ID_LOW,
        SEL_ID_HIGH, SEL_COUNTER_SELECT, SEL_IRQ_STATUS, SEL_IRQ_MASK, SEL_NONE
    } reg_sel_t;

    typedef struct packed {
        logic [7:0] held_state;
        logic final_flag;
        logic run_d;
        logic final_rise;
        logic [31:0] counter_snap;
        logic [7:0] action_snap;
    } snap_state_t;

    typedef struct packed {
        logic [63:0] id_value;
        logic id_rise;
    } id_state_t;

endpackage

//--- shared/snap_if.sv
`timescale 1ns/1ps
interface snap_if;
    logic snap_strobe;
    logic [31:0] state_word;
    logic [31:0] counter_snap;
    logic [7:0] action_snap;
    logic final_flag;
    logic final_rise;
    logic [63:0] id_value;
    logic id_rise;

    modport top (
        output snap_strobe,
        input state_word, counter_snap, action_snap, final_flag, final_rise,
        input id_value, id_rise
    );
    modport snap (
        input snap_strobe,
        output state_word, counter_snap, action_snap, final_flag, final_rise
    );
    modport idcap (
        output id_value, id_rise
    );
endinterface

//--- verilog/state_snapshot.sv
`timescale 1ns/1ps
`include "state_readback_regs.svh"
module state_snapshot (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run_control,
    input wire logic [7:0] trig_state,
    input wire logic state_advance,
    input wire logic [7:0] advance_target,
    input wire logic count_break_final,
    input wire logic [31:0] counter_value,
    input wire logic [7:0] action_levels,
    snap_if.snap bus
);
    import state_readback_pkg::*;

    snap_state_t s_reg;
    snap_state_t s_next;
    logic [7:0] live_state;
    logic [7:0] shown_state;
    logic set_final;

    always_comb begin
        live_state = trig_state & 8'((1 << `TRIGGER_STATE_COUNT) - 1);
        // loop break at final count or advance into a zero selection
        set_final = count_break_final || (state_advance && advance_target == 8'h00);
        s_next = s_reg;
        s_next.run_d = run_control;
        s_next.final_rise = set_final && !s_reg.final_flag;
        // new run clears the flag, a simultaneous set still wins
        if (run_control && !s_reg.run_d) begin
            s_next.final_flag = 1'b0;
        end
        if (set_final) begin
            s_next.final_flag = 1'b1;
        end
        if (set_final && !s_reg.final_flag) begin
            s_next.held_state = live_state;
        end
        // counter and action caught on the same edge as the state read
        if (bus.snap_strobe) begin
            s_next.counter_snap = counter_value;
            s_next.action_snap = action_levels;
        end
        shown_state = s_reg.final_flag ? s_reg.held_state : live_state;
        bus.state_word = 32'h0000_0000;
        bus.state_word[`FINAL_FLAG_BIT] = s_reg.final_flag;
        if (run_control) begin
            bus.state_word[7:0] = shown_state;
        end
        bus.counter_snap = s_reg.counter_snap;
        bus.action_snap = s_reg.action_snap;
        bus.final_flag = s_reg.final_flag;
        bus.final_rise = s_reg.final_rise;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.held_state <= `STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

//--- verilog/id_capture.sv
`timescale 1ns/1ps
`include "state_readback_regs.svh"
module id_capture (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic addr_req_match,
    input wire logic [63:0] txn_id,
    snap_if.idcap bus
);
    import state_readback_pkg::*;

    id_state_t s_reg;
    id_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.id_rise = 1'b0;
        if (`ID_CAPTURE_OPTION == 1 && addr_req_match) begin
            s_next.id_value = txn_id;
            s_next.id_rise = 1'b1;
        end
        bus.id_value = s_reg.id_value;
        bus.id_rise = s_reg.id_rise;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

//--- verilog/state_readback.sv
// Functional notes
// - counter select bits 2:0 pick position one, bits 5:3 position two
// - bits 8:6 and 11:9 pick positions three, four only above 64-bit groups
// - reading current state also latches counter and action snapshots
// - current state bit 31 is one once the final flag is set, else zero
// - final flag set by final loop count or advance to zero selection
// - low bits show one-hot state while run is set, zero otherwise
// - after final flag, state field holds the state active at that moment
// - counter snapshot returns value caught at the last current-state read
// - counter snapshot after final state may be unpredictable
// - action snapshot: 7:4 output value, 3 trace, 2 clock stop, 1:0 triggers
// - address-request match captures the transaction identifier
// - identifier bits 31:0 in low register, 63:32 in high register
// - each select field chooses states 0 to 7; 4-7 need eight states
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "state_readback_regs.svh"
module state_readback (
    input wire logic aclk,
    input wire logic aresetn,

    // register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,

    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,

    // analyzer side
    input wire logic run_control,
    input wire logic [7:0] trig_state,
    input wire logic state_advance,
    input wire logic [7:0] advance_target,
    input wire logic count_break_final,
    input wire logic [31:0] counter_value,
    input wire logic [7:0] action_levels,
    input wire logic addr_req_match,
    input wire logic [63:0] txn_id,

    // trace packer side
    output logic [2:0] pos1_select,
    output logic [2:0] pos2_select,
    output logic [2:0] pos3_select,
    output logic [2:0] pos4_select,
    output logic final_state_flag,
    output logic irq
);
    import state_readback_pkg::*;

    typedef struct packed {
        // write channel
        wr_state_t wr_state;
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;

        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;

        logic bvalid;
        logic [1:0] bresp;

        // read channel
        rd_state_t rd_state;
        logic arready;

        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;

        // registers
        logic [11:0] counter_select;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;

        logic irq;
        logic final_flag;

        logic [2:0] pos1;
        logic [2:0] pos2;
        logic [2:0] pos3;
        logic [2:0] pos4;
    } top_state_t;

    top_state_t s_reg;
    top_state_t s_next;
    snap_if link ();

    // word address decode, shared by read and write paths
    function automatic reg_sel_t decode(input logic [7:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        // unaligned never matches
        if (addr[1:0] == 2'h0) begin
            case (addr)
                `CUR_STATE_OFFSET: sel = SEL_CUR_STATE;
                `COUNTER_SNAP_OFFSET: sel = SEL_COUNTER_SNAP;
                `ACTION_SNAP_OFFSET: sel = SEL_ACTION_SNAP;
                `ID_LOW_OFFSET: sel = SEL_ID_LOW;
                `ID_HIGH_OFFSET: sel = SEL_ID_HIGH;
                `COUNTER_SELECT_OFFSET: sel = SEL_COUNTER_SELECT;
                `IRQ_STATUS_OFFSET: sel = SEL_IRQ_STATUS;
                `IRQ_MASK_OFFSET: sel = SEL_IRQ_MASK;
                default: sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // a select naming a state that is not built is driven to the trace packer as state 0
    function automatic logic [2:0] legal_state(input logic [2:0] sel);
        logic [2:0] r;
        r = sel;
        if (32'(sel) >= `TRIGGER_STATE_COUNT) begin
            r = 3'h0;
        end
        return r;
    endfunction

    // byte-lane merge of a write into a 32-bit image
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        // only enabled lanes change
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    // snapshots
    state_snapshot i_state_snapshot (
        .aclk(aclk),
        .aresetn(aresetn),
        .run_control(run_control),
        .trig_state(trig_state),
        .state_advance(state_advance),
        .advance_target(advance_target),
        .count_break_final(count_break_final),
        .counter_value(counter_value),
        .action_levels(action_levels),
        .bus(link.snap)
    );

    // identifier capture
    id_capture i_id_capture (
        .aclk(aclk),
        .aresetn(aresetn),
        .addr_req_match(addr_req_match),
        .txn_id(txn_id),
        .bus(link.idcap)
    );

    // decode and write helpers
    reg_sel_t rd_sel;
    reg_sel_t wr_sel;
    logic ar_take;
    logic [1:0] irq_events;
    logic [1:0] irq_clear;
    logic [31:0] rd_word;
    logic [31:0] merged;

    always_comb begin
        // all holds by default
        s_next = s_reg;
        rd_sel = decode(s_axi_araddr);
        wr_sel = decode(s_reg.awaddr);
        ar_take = s_axi_arvalid && s_reg.arready;
        irq_clear = 2'h0;
        merged = 32'h0000_0000;
        rd_word = 32'h0000_0000;

        // read path: the state read drives the snapshot strobe
        link.snap_strobe = ar_take && rd_sel == SEL_CUR_STATE;

        // unmapped words read zero
        case (rd_sel)
            SEL_CUR_STATE: rd_word = link.state_word;
            SEL_COUNTER_SNAP: rd_word = link.counter_snap;
            SEL_ACTION_SNAP: rd_word = {24'h00_0000, link.action_snap};
            SEL_ID_LOW: rd_word = link.id_value[31:0];
            SEL_ID_HIGH: rd_word = link.id_value[63:32];
            SEL_COUNTER_SELECT: rd_word = {20'h0_0000, s_reg.counter_select};
            SEL_IRQ_STATUS: rd_word = {30'h0000_0000, s_reg.irq_status};
            SEL_IRQ_MASK: rd_word = {30'h0000_0000, s_reg.irq_mask};
            default: rd_word = 32'h0000_0000;
        endcase

        // one read at a time
        case (s_reg.rd_state)
            RD_IDLE: begin
                if (ar_take) begin
                    s_next.arready = 1'b0;
                    s_next.rvalid = 1'b1;
                    s_next.rdata = rd_word;
                    s_next.rresp = (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
                    s_next.rd_state = RD_RESP;
                end
            end

            RD_RESP: begin
                if (s_axi_rready) begin
                    s_next.rvalid = 1'b0;
                    s_next.arready = 1'b1;
                    s_next.rd_state = RD_IDLE;
                end
            end
            default: s_next.rd_state = RD_IDLE;
        endcase

        // write path: address and data taken in either order
        case (s_reg.wr_state)
            WR_COLLECT: begin
                if (s_axi_awvalid && s_reg.awready) begin
                    s_next.awready = 1'b0;
                    s_next.aw_held = 1'b1;
                    s_next.awaddr = s_axi_awaddr;
                end

                if (s_axi_wvalid && s_reg.wready) begin
                    s_next.wready = 1'b0;
                    s_next.w_held = 1'b1;
                    s_next.wdata = s_axi_wdata;
                    s_next.wstrb = s_axi_wstrb;
                end

                // both halves held
                if (s_reg.aw_held && s_reg.w_held) begin
                    s_next.aw_held = 1'b0;
                    s_next.w_held = 1'b0;
                    s_next.bvalid = 1'b1;
                    s_next.bresp = `RESP_OKAY;
                    s_next.wr_state = WR_RESP;
                    case (wr_sel)
                        SEL_COUNTER_SELECT: begin
                            merged = merge({20'h0_0000, s_reg.counter_select},
                                           s_reg.wdata, s_reg.wstrb);
                            s_next.counter_select = merged[11:0];
                        end
                        SEL_IRQ_STATUS: begin
                            if (s_reg.wstrb[0]) begin
                                irq_clear = s_reg.wdata[1:0];
                            end
                        end
                        SEL_IRQ_MASK: begin
                            if (s_reg.wstrb[0]) begin
                                s_next.irq_mask = s_reg.wdata[1:0];
                            end
                        end
                        SEL_NONE: s_next.bresp = `RESP_SLVERR;
                        default: s_next.bresp = `RESP_OKAY;
                    endcase
                end
            end

            WR_RESP: begin
                if (s_axi_bready) begin
                    s_next.bvalid = 1'b0;
                    s_next.awready = 1'b1;
                    s_next.wready = 1'b1;
                    s_next.wr_state = WR_COLLECT;
                end
            end
            default: s_next.wr_state = WR_COLLECT;
        endcase

        // sticky events, write one to clear, a new event wins
        irq_events = 2'h0;
        irq_events[`IRQ_FINAL_BIT] = link.final_rise;
        irq_events[`IRQ_ID_BIT] = link.id_rise;
        s_next.irq_status = (s_reg.irq_status & ~irq_clear) | irq_events;
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);
        // one cycle behind the snapshot
        s_next.final_flag = link.final_flag;

        // position selects handed to the trace packer
        s_next.pos1 = legal_state(s_next.counter_select[`POS1_LSB +: `SELECT_FIELD_W]);
        s_next.pos2 = legal_state(s_next.counter_select[`POS2_LSB +: `SELECT_FIELD_W]);
        s_next.pos3 = 3'h0;
        s_next.pos4 = 3'h0;

        // wide groups only
        if (`CAPTURE_GROUP_WIDTH > 64) begin
            s_next.pos3 = legal_state(s_next.counter_select[`POS3_LSB +: `SELECT_FIELD_W]);
            s_next.pos4 = legal_state(s_next.counter_select[`POS4_LSB +: `SELECT_FIELD_W]);
        end
    end

    // reset leaves every channel ready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.wr_state <= WR_COLLECT;
            s_reg.rd_state <= RD_IDLE;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
            s_reg.counter_select <= `COUNTER_SELECT_RESET;
            s_reg.irq_mask <= `IRQ_MASK_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flops
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;

    assign pos1_select = s_reg.pos1;
    assign pos2_select = s_reg.pos2;
    assign pos3_select = s_reg.pos3;
    assign pos4_select = s_reg.pos4;

    assign final_state_flag = s_reg.final_flag;
    assign irq = s_reg.irq;
endmodule

//--- verif/state_readback_properties.sv
`timescale 1ns/1ps
`include "state_readback_regs.svh"
module state_readback_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic run_control,
    input wire logic [7:0] trig_state,
    input wire logic state_advance,
    input wire logic [7:0] advance_target,
    input wire logic count_break_final,
    input wire logic [2:0] pos1_select,
    input wire logic [2:0] pos2_select,
    input wire logic [2:0] pos3_select,
    input wire logic [2:0] pos4_select,
    input wire logic final_state_flag,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [11:0] wsel;
    assign wsel = s_axi_wdata[11:0];
    sequence s_state_rd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `CUR_STATE_OFFSET;
    endsequence
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_sel_wr;
        s_wr_both ##0 (s_axi_awaddr == `COUNTER_SELECT_OFFSET && s_axi_wstrb == 4'hf);
    endsequence
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_wr_answer;
        s_wr_both |-> ##2 s_axi_bvalid;
    endproperty
    property p_wr_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    property p_final_set;
        count_break_final || (state_advance && advance_target == 8'h00) |-> ##2 final_state_flag;
    endproperty
    property p_word;
        s_state_rd |=> s_axi_rdata[31] == final_state_flag && s_axi_rdata[30:8] == 23'h0
            && ($past(run_control) || s_axi_rdata[7:0] == 8'h00);
    endproperty
    property p_live;
        s_state_rd ##0 run_control ##1 !final_state_flag |-> s_axi_rdata[7:0] == $past(trig_state);
    endproperty
    property p_sel;
        s_sel_wr |-> ##3 {pos4_select, pos3_select, pos2_select, pos1_select} == $past(wsel, 3);
    endproperty
    property p_irq_fall;
        $fell(irq) |-> s_axi_bvalid || !$past(aresetn);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
    a_final_set: assert property (p_final_set) else $error("final flag not set");
    a_word: assert property (p_word) else $error("state word bits wrong");
    a_live: assert property (p_live) else $error("live state wrong");
    a_sel: assert property (p_sel) else $error("select fields wrong");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule
bind state_readback state_readback_properties i_state_readback_properties (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .run_control, .trig_state,
    .state_advance, .advance_target, .count_break_final, .pos1_select, .pos2_select,
    .pos3_select, .pos4_select, .final_state_flag, .irq);

//--- verif/state_readback_tb.sv
`timescale 1ns/1ps
`include "state_readback_regs.svh"
module state_readback_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, trig_state, advance_target, action_levels;
    logic [2:0] s_axi_awprot, s_axi_arprot, pos1_select, pos2_select, pos3_select, pos4_select;
    logic [31:0] s_axi_wdata, s_axi_rdata, counter_value, rd, cnt_exp, d;
    logic [3:0] s_axi_wstrb, s;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic run_control, state_advance, count_break_final, addr_req_match, final_state_flag, irq;
    logic [63:0] txn_id, id;
    logic [7:0] act_exp, st;
    logic [11:0] sel_exp;
    logic run_r;
    int mismatches = 0;
    int comparisons = 0;
    state_readback i_state_readback (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .run_control, .trig_state, .state_advance,
        .advance_target, .count_break_final, .counter_value, .action_levels,
        .addr_req_match, .txn_id, .pos1_select, .pos2_select, .pos3_select, .pos4_select,
        .final_state_flag, .irq);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic wrap_up();
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait step
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 200) begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] b);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= b;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            tick(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // k: 0 final loop count, 1 advance to zero, 2 advance elsewhere, 3 id match
    task automatic evt(input int k);
        @(posedge aclk);
        count_break_final <= (k == 0);
        state_advance <= (k == 1 || k == 2);
        advance_target <= (k == 1) ? 8'h00 : 8'h20;
        addr_req_match <= (k == 3);
        @(posedge aclk);
        {count_break_final, state_advance, addr_req_match} <= 3'h0;
    endtask
    function automatic logic [31:0] word_exp(logic f, logic run, logic [7:0] v);
        return {f, 23'h0, run ? v : 8'h00};
    endfunction
    function automatic logic [11:0] merge(logic [11:0] old, logic [31:0] v, logic [3:0] b);
        return {b[1] ? v[11:8] : old[11:8], b[0] ? v[7:0] : old[7:0]};
    endfunction
    initial begin
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
            s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
        {run_control, trig_state, state_advance, advance_target, count_break_final,
            counter_value, action_levels, addr_req_match, txn_id} = '0;
        void'($urandom(66630));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(`COUNTER_SELECT_OFFSET);
        chk(rd, 32'h0);
        rd_reg(`CUR_STATE_OFFSET);
        chk(rd, 32'h0);
        for (int i = 0; i < 24; i++) begin
            st = 8'h01 << ($urandom % 8);
            run_r = 1'($urandom);
            cnt_exp = $urandom;
            act_exp = 8'($urandom);
            @(posedge aclk);
            run_control <= run_r;
            trig_state <= st;
            counter_value <= cnt_exp;
            action_levels <= act_exp;
            rd_reg(`CUR_STATE_OFFSET);
            chk(rd, word_exp(1'b0, run_r, st));
            @(posedge aclk);
            counter_value <= $urandom;
            action_levels <= 8'($urandom);
            rd_reg(`COUNTER_SNAP_OFFSET);
            chk(rd, cnt_exp);
            rd_reg(`ACTION_SNAP_OFFSET);
            chk(rd, {24'h0, act_exp});
        end
        sel_exp = 12'h000;
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
            s = (i < 3) ? 4'hf : 4'($urandom);
            wr(`COUNTER_SELECT_OFFSET, d, s);
            sel_exp = merge(sel_exp, d, s);
            repeat (2) @(posedge aclk);
            chk({20'h0, pos4_select, pos3_select, pos2_select, pos1_select},
                {20'h0, sel_exp});
            rd_reg(`COUNTER_SELECT_OFFSET);
            chk(rd, {20'h0, sel_exp});
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge aclk);
            run_control <= 1'b0;
            @(posedge aclk);
            run_control <= 1'b1;
            trig_state <= 8'h04;
            evt(k);
            @(posedge aclk);
            trig_state <= 8'h10;
            repeat (2) @(posedge aclk);
            chk({31'h0, final_state_flag}, {31'h0, k != 2});
            rd_reg(`CUR_STATE_OFFSET);
            chk(rd, word_exp(k != 2, 1'b1, (k != 2) ? 8'h04 : 8'h10));
        end
        chk({31'h0, irq}, 32'h0);
        wr(`IRQ_MASK_OFFSET, 32'h3, 4'h1);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(`IRQ_STATUS_OFFSET, 32'h1, 4'h1);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        id = {$urandom, $urandom};
        @(posedge aclk);
        run_control <= 1'b0;
        txn_id <= id;
        evt(3);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rd_reg(`ID_LOW_OFFSET);
        chk(rd, id[31:0]);
        rd_reg(`ID_HIGH_OFFSET);
        chk(rd, id[63:32]);
        rd_reg(`IRQ_STATUS_OFFSET);
        chk(rd, 32'h2);
        rd_reg(`IRQ_MASK_OFFSET);
        chk(rd, 32'h3);
        @(posedge aclk);
        counter_value <= 32'h1234_5678;
        rd_reg(`CUR_STATE_OFFSET);
        wr(`COUNTER_SNAP_OFFSET, 32'hffff_ffff, 4'hf);
        chk({30'h0, resp}, {30'h0, `RESP_OKAY});
        rd_reg(`COUNTER_SNAP_OFFSET);
        chk(rd, 32'h1234_5678);
        wr(8'h40, 32'h0, 4'hf);
        chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
        rd_reg(8'h40);
        chk({rd[29:0], resp}, {30'h0, `RESP_SLVERR});
        wrap_up();
    end
endmodule
